// >>> hdl/agcs_gain_sequencer.sv
// Gain sequencer top: envelope-driven gain stepping with an APB register file.
// Assumes a digitised envelope and synchronous select pins on core_clk.
`timescale 1ns/1ps
`include "agcs_defines.svh"
module agcs_gain_sequencer #(
  parameter int TIMER_W = 28,
  parameter int ATTACK_CYCLES = `AGCS_ATTACK_CYCLES,
  parameter int RELEASE_CYCLES = `AGCS_RELEASE_CYCLES,
  parameter int HOLD_CYCLES = `AGCS_HOLD_CYCLES
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Function select pins
  input wire logic function_select_high,
  input wire logic function_select_low,
  // Envelope detector, 0.5 dB codes
  input wire logic [7:0] env_level,
  // Gain stage, 0.5 dB codes
  output logic [7:0] gain_code
);
  localparam logic [TIMER_W-1:0] ATTACK_LOAD = TIMER_W'(ATTACK_CYCLES);
  localparam logic [TIMER_W-1:0] RELEASE_LOAD = TIMER_W'(RELEASE_CYCLES);
  localparam logic [TIMER_W-1:0] HOLD_LOAD = TIMER_W'(HOLD_CYCLES);

  // Mode decode helpers
  function automatic logic mode_comp(input agcs_pkg::agcs_mode_t m);
    mode_comp = (m == agcs_pkg::AGCS_MODE_COMP) || (m == agcs_pkg::AGCS_MODE_GATE);
  endfunction
  function automatic logic mode_gate(input agcs_pkg::agcs_mode_t m);
    mode_gate = (m == agcs_pkg::AGCS_MODE_GATE);
  endfunction

  // Registers
  logic [7:0] fixed_reg, maxg_reg, ming_reg, limit_reg, gate_reg;
  logic [1:0] ratio_reg;
  agcs_pkg::agcs_mode_t mode_reg;
  logic [7:0] gain_reg, gain_next;
  logic over_prev_reg;
  logic [31:0] prdata_reg;
  logic pready_reg, pslverr_reg;

  // Sequencer signals
  logic attack_done, release_done, hold_done;
  logic step_up, step_down, timers_restart;
  logic [8:0] out_level;
  logic over_limit, room_up, gate_block;
  logic [8:0] knee, target_wide;
  logic [7:0] target;

  // APB decode
  logic apb_setup, apb_commit, addr_ok;
  assign apb_setup = psel && penable && !pready_reg;
  assign apb_commit = psel && penable && pready_reg;
  assign addr_ok = (paddr == `AGCS_GAIN_CFG_OFS) || (paddr == `AGCS_LEVEL_CFG_OFS) ||
                   (paddr == `AGCS_STATUS_OFS);

  // Select pins sampled each cycle
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      mode_reg <= agcs_pkg::AGCS_MODE_OFF;
    end else begin
      mode_reg <= agcs_pkg::agcs_mode_t'({function_select_high, function_select_low});
    end
  end

  // Configuration registers
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      fixed_reg <= `AGCS_FIXED_RST;
      maxg_reg <= `AGCS_MAXG_RST;
      ming_reg <= `AGCS_MING_RST;
      limit_reg <= `AGCS_LIMIT_RST;
      gate_reg <= `AGCS_GATE_RST;
      ratio_reg <= `AGCS_RATIO_RST;
    end else if (apb_commit && pwrite) begin
      if (paddr == `AGCS_GAIN_CFG_OFS) begin
        fixed_reg <= pwdata[`AGCS_FIXED_LSB +: 8];
        maxg_reg <= pwdata[`AGCS_MAXG_LSB +: 8];
        ming_reg <= pwdata[`AGCS_MING_LSB +: 8];
      end else if (paddr == `AGCS_LEVEL_CFG_OFS) begin
        limit_reg <= pwdata[`AGCS_LIMIT_LSB +: 8];
        gate_reg <= pwdata[`AGCS_GATE_LSB +: 8];
        ratio_reg <= pwdata[`AGCS_RATIO_LSB +: 2];
      end
    end
  end

  // APB answer, one wait state
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0;
    end else begin
      pready_reg <= apb_setup;
      pslverr_reg <= apb_setup && !addr_ok;
      if (apb_setup && !pwrite) begin
        unique case (paddr)
          `AGCS_GAIN_CFG_OFS: prdata_reg <= {8'h0, ming_reg, maxg_reg, fixed_reg};
          `AGCS_LEVEL_CFG_OFS: prdata_reg <= {14'h0, ratio_reg, gate_reg, limit_reg};
          `AGCS_STATUS_OFS: prdata_reg <= {19'h0, !release_done, !attack_done, over_limit,
                                           mode_reg, gain_reg};
          default: prdata_reg <= 32'h0;
        endcase
      end else begin
        prdata_reg <= 32'h0;
      end
    end
  end

  // Output level and limit comparison
  assign out_level = {1'b0, env_level} + {1'b0, gain_reg};
  assign over_limit = out_level > {1'b0, limit_reg};
  assign room_up = (out_level + 9'h001) <= {1'b0, limit_reg};
  assign gate_block = mode_gate(mode_reg) && (env_level < gate_reg);

  // Desired gain: fixed, plus compressed boost below the knee
  assign knee = {1'b0, limit_reg} - {1'b0, fixed_reg};
  always_comb begin
    target_wide = {1'b0, fixed_reg};
    if (mode_comp(mode_reg) && !knee[8] && ({1'b0, env_level} < knee)) begin
      target_wide = {1'b0, fixed_reg} + ((knee - {1'b0, env_level}) >> ratio_reg);
    end
    if (target_wide > {1'b0, maxg_reg}) begin
      target = maxg_reg;
    end else if (target_wide < {1'b0, ming_reg}) begin
      target = ming_reg;
    end else begin
      target = target_wide[7:0];
    end
  end

  // Step decisions
  always_comb begin
    step_down = 1'b0;
    step_up = 1'b0;
    if (mode_reg != agcs_pkg::AGCS_MODE_OFF) begin
      if ((over_limit || gain_reg > target) && gain_reg > ming_reg) begin
        if (over_limit && !over_prev_reg) begin
          step_down = 1'b1;
        end else begin
          step_down = attack_done;
        end
      end else if (!over_limit && room_up && gain_reg < target && gain_reg < maxg_reg &&
                   !gate_block) begin
        step_up = release_done && hold_done;
      end
    end
  end
  assign timers_restart = step_up || step_down;

  // Gain register
  always_comb begin
    gain_next = gain_reg;
    if (mode_reg == agcs_pkg::AGCS_MODE_OFF) begin
      gain_next = fixed_reg;
    end else if (step_down) begin
      gain_next = gain_reg - 8'h01;
    end else if (step_up) begin
      gain_next = gain_reg + 8'h01;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      gain_reg <= `AGCS_FIXED_RST;
    end else begin
      gain_reg <= gain_next;
    end
  end

  // Limit crossing memory
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      over_prev_reg <= 1'b0;
    end else begin
      over_prev_reg <= over_limit && (mode_reg != agcs_pkg::AGCS_MODE_OFF);
    end
  end

  // Attack, release and hold timers
  agcs_step_timer #(.WIDTH(TIMER_W)) u_attack (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .restart(timers_restart),
    .load(ATTACK_LOAD),
    .done(attack_done)
  );
  agcs_step_timer #(.WIDTH(TIMER_W)) u_release (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .restart(timers_restart),
    .load(RELEASE_LOAD),
    .done(release_done)
  );
  agcs_step_timer #(.WIDTH(TIMER_W)) u_hold (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .restart(timers_restart),
    .load(HOLD_LOAD),
    .done(hold_done)
  );

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign gain_code = gain_reg;

  // Checks
  logic active_now;
  assign active_now = (mode_reg != agcs_pkg::AGCS_MODE_OFF);

  a_gain_step_size: assert property (@(posedge core_clk) disable iff (!reset_n)
    ($past(active_now) && active_now && gain_reg != $past(gain_reg)) |->
      (gain_reg == $past(gain_reg) + 8'h01 || gain_reg == $past(gain_reg) - 8'h01))
    else $error("gain moved by more than one step");

  a_first_drop: assert property (@(posedge core_clk) disable iff (!reset_n)
    (active_now && over_limit && !over_prev_reg && gain_reg > ming_reg) |=>
      (gain_reg == $past(gain_reg) - 8'h01 && !attack_done && !release_done) ||
      (mode_reg == agcs_pkg::AGCS_MODE_OFF))
    else $error("first limit crossing did not drop gain and restart timers");

  a_attack_block: assert property (@(posedge core_clk) disable iff (!reset_n)
    (active_now && over_prev_reg && !attack_done) |=>
      (gain_reg >= $past(gain_reg) || mode_reg == agcs_pkg::AGCS_MODE_OFF))
    else $error("gain dropped before attack expired");

  a_attack_drop: assert property (@(posedge core_clk) disable iff (!reset_n)
    (active_now && over_limit && over_prev_reg && attack_done && gain_reg > ming_reg) |=>
      (gain_reg == $past(gain_reg) - 8'h01 || mode_reg == agcs_pkg::AGCS_MODE_OFF))
    else $error("attack expiry with level over limit did not drop gain");

  a_release_rise: assert property (@(posedge core_clk) disable iff (!reset_n)
    (active_now && $past(active_now) && gain_reg > $past(gain_reg)) |->
      ($past(release_done) && $past(hold_done) && !release_done))
    else $error("gain rose before release expired");

  a_gain_bounds: assert property (@(posedge core_clk) disable iff (!reset_n)
    ($past(active_now) && $past(gain_reg) <= maxg_reg && $stable(maxg_reg)) |->
      (gain_reg <= maxg_reg))
    else $error("gain above maximum");

  a_mode_decode: assert property (@(posedge core_clk) disable iff (!reset_n)
    ##1 ((mode_gate(mode_reg) == $past(function_select_high && function_select_low)) &&
      (mode_comp(mode_reg) == $past(function_select_high))))
    else $error("select pins decoded wrongly");

  a_steady_hold: assert property (@(posedge core_clk) disable iff (!reset_n)
    (active_now && !step_up && !step_down) |=>
      (gain_reg == $past(gain_reg) || !active_now))
    else $error("gain moved without a step decision");

  a_release_block: assert property (@(posedge core_clk) disable iff (!reset_n)
    (active_now && !release_done) |=> (gain_reg <= $past(gain_reg) || !active_now))
    else $error("gain rose while release running");

  a_timer_restart: assert property (@(posedge core_clk) disable iff (!reset_n)
    (active_now && $past(active_now) && gain_reg != $past(gain_reg)) |->
      (!attack_done && !release_done))
    else $error("timers not restarted on a gain step");

  a_ceiling_hold: assert property (@(posedge core_clk) disable iff (!reset_n)
    (active_now && gain_reg >= maxg_reg) |=> (gain_reg <= $past(gain_reg) || !active_now))
    else $error("gain rose at the ceiling");

  a_apb_idle: assert property (@(posedge core_clk) disable iff (!reset_n)
    (!psel) |=> (!pready))
    else $error("apb answer without a request");

  a_disabled_fixed: assert property (@(posedge core_clk) disable iff (!reset_n)
    (!active_now ##1 !active_now) |-> (gain_reg == $past(fixed_reg)))
    else $error("disabled mode did not hold fixed gain");

  a_gate_hold: assert property (@(posedge core_clk) disable iff (!reset_n)
    (mode_gate(mode_reg) && env_level < gate_reg && !over_limit) |=>
      (gain_reg <= $past(gain_reg) || !active_now))
    else $error("gain rose while gate closed");

  a_apb_answer: assert property (@(posedge core_clk) disable iff (!reset_n)
    (psel && penable && !pready) |=> (pready ##1 !pready))
    else $error("apb answer not a single cycle");
endmodule

// >>> hdl/agcs_defines.svh
// Constants of the gain sequencer: register map, fields, resets, timing.
// Assumes a 100 MHz core clock and gain codes in 0.5 dB units.
`ifndef AGCS_DEFINES_SVH
`define AGCS_DEFINES_SVH

// Register byte offsets
`define AGCS_GAIN_CFG_OFS 12'h000
`define AGCS_LEVEL_CFG_OFS 12'h004
`define AGCS_STATUS_OFS 12'h008

// Gain configuration fields
`define AGCS_FIXED_LSB 0
`define AGCS_MAXG_LSB 8
`define AGCS_MING_LSB 16
// Level configuration fields
`define AGCS_LIMIT_LSB 0
`define AGCS_GATE_LSB 8
`define AGCS_RATIO_LSB 16
// Status fields
`define AGCS_ST_GAIN_LSB 0
`define AGCS_ST_MODE_LSB 8
`define AGCS_ST_OVER_BIT 10
`define AGCS_ST_ATTACK_BIT 11
`define AGCS_ST_RELEASE_BIT 12

// Reset values, gains in 0.5 dB codes, levels as 2*(dBV+64)
`define AGCS_FIXED_RST 8'h0c
`define AGCS_MAXG_RST 8'h3c
`define AGCS_MING_RST 8'h00
`define AGCS_LIMIT_RST 8'h92
`define AGCS_GATE_RST 8'h3c
`define AGCS_RATIO_RST 2'h1

// Timing
`define AGCS_CLK_MHZ 100
`define AGCS_ATTACK_TIME_US 6400
`define AGCS_RELEASE_TIME_MS 1810
`define AGCS_HOLD_TIME_MS 10
`define AGCS_ATTACK_CYCLES (`AGCS_ATTACK_TIME_US * `AGCS_CLK_MHZ)
`define AGCS_RELEASE_CYCLES (`AGCS_RELEASE_TIME_MS * 1000 * `AGCS_CLK_MHZ)
`define AGCS_HOLD_CYCLES (`AGCS_HOLD_TIME_MS * 1000 * `AGCS_CLK_MHZ)

`endif

// >>> hdl/agcs_pkg.sv
// Types of the gain sequencer.
// Assumes nothing beyond the defines header.
package agcs_pkg;
  typedef enum logic [1:0] {
    AGCS_MODE_OFF = 2'h0,
    AGCS_MODE_LIMIT = 2'h1,
    AGCS_MODE_COMP = 2'h2,
    AGCS_MODE_GATE = 2'h3
  } agcs_mode_t;
endpackage

// >>> hdl/agcs_step_timer.sv
// Reloadable down-counter for attack, release and hold intervals.
// Assumes restart is a one-cycle pulse in the core clock domain.
`timescale 1ns/1ps
module agcs_step_timer #(
  parameter int WIDTH = 28
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Control
  input wire logic restart,
  input wire logic [WIDTH-1:0] load,
  // Status
  output logic done
);
  logic [WIDTH-1:0] count_reg;

  // Count down to zero after each restart
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      count_reg <= '0;
    end else if (restart) begin
      count_reg <= load;
    end else if (count_reg != '0) begin
      count_reg <= count_reg - 1'b1;
    end
  end

  assign done = (count_reg == '0);
endmodule

// >>> testbench/agcs_env_model.sv
// Partner model: host select pins and envelope detector.
// Assumes bench requests, applied right after core_clk rising edges.
`timescale 1ns/1ps
module agcs_env_model (
  // Clock
  input wire logic core_clk,
  // Requests from the bench
  input wire logic [1:0] mode_req,
  input wire logic [7:0] env_req,
  // Toward the sequencer
  output logic function_select_high,
  output logic function_select_low,
  output logic [7:0] env_level
);
  initial begin
    function_select_high = 1'b0;
    function_select_low = 1'b0;
    env_level = 8'h00;
  end
  // Pins are static levels, changed only on a clock edge
  always @(posedge core_clk) begin
    {function_select_high, function_select_low} <= mode_req;
    env_level <= env_req;
  end
endmodule

// >>> testbench/agcs_gain_sequencer_tb.sv
// Testbench of the gain sequencer with shortened timers.
// Assumes the design files and the partner model are compiled first.
`timescale 1ns/1ps
module agcs_gain_sequencer_tb;
  logic core_clk, reset_n, psel, penable, pwrite, pready, pslverr, er, watch;
  logic function_select_high, function_select_low;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] env_level, gain_code, env_req, prev;
  logic [1:0] mode_req;
  int num_errors, checks;

  agcs_gain_sequencer #(.ATTACK_CYCLES(8), .RELEASE_CYCLES(20), .HOLD_CYCLES(4)) dut (
    .core_clk(core_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .function_select_high(function_select_high),
    .function_select_low(function_select_low), .env_level(env_level),
    .gain_code(gain_code));

  agcs_env_model partner (
    .core_clk(core_clk), .mode_req(mode_req), .env_req(env_req),
    .function_select_high(function_select_high),
    .function_select_low(function_select_low), .env_level(env_level));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      num_errors++;
      summarize();
    end
    @(posedge core_clk);
  endtask

  task automatic wait_gain(input logic [7:0] g, input int lim);
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (gain_code !== g && n < lim);
    check("gain", {24'h0, gain_code}, {24'h0, g});
    if (gain_code !== g) begin
      summarize();
    end
  endtask

  task automatic stay(input logic [7:0] g, input int n);
    logic [7:0] s;
    s = g;
    repeat (n) begin
      @(posedge core_clk);
      if (gain_code !== g) begin
        s = gain_code;
      end
    end
    check("hold", {24'h0, s}, {24'h0, g});
  endtask

  // Every gain change while watch is set is a single step
  always @(posedge core_clk) begin
    prev <= gain_code;
    if (watch && gain_code !== prev) begin
      check("step", {31'h0, (gain_code - prev == 8'h01) || (prev - gain_code == 8'h01)}, 1);
    end
  end

  initial begin
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    mode_req = 2'h0;
    env_req = 8'h00;
    watch = 1'b0;
    num_errors = 0;
    checks = 0;
    repeat (16) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    watch <= 1'b1;
    check("gain", {24'h0, gain_code}, 32'h0c);
    apb(1'b0, 12'h000, 32'h0, rd, er);
    check("gain_cfg", rd, 32'h00003c0c);
    apb(1'b0, 12'h004, 32'h0, rd, er);
    check("level_cfg", rd, 32'h00013c92);
    apb(1'b0, 12'h00c, 32'h0, rd, er);
    check("unmapped", rd | er, 32'h1);
    apb(1'b1, 12'h008, 32'hffffffff, rd, er);
    apb(1'b0, 12'h008, 32'h0, rd, er);
    check("status", rd, 32'h0000000c);
    // Loud input with the function disabled, then limit mode attack and release
    env_req <= 8'h8c;
    stay(8'h0c, 40);
    mode_req <= 2'h1;
    wait_gain(8'h0b, 6);
    stay(8'h0b, 5);
    wait_gain(8'h0a, 12);
    env_req <= 8'h64;
    stay(8'h0a, 10);
    wait_gain(8'h0b, 40);
    wait_gain(8'h0c, 40);
    stay(8'h0c, 60);
    // Compression with a low ceiling
    apb(1'b1, 12'h000, 32'h00000e0c, rd, er);
    mode_req <= 2'h2;
    wait_gain(8'h0d, 40);
    wait_gain(8'h0e, 40);
    stay(8'h0e, 60);
    watch <= 1'b0;
    mode_req <= 2'h0;
    wait_gain(8'h0c, 10);
    watch <= 1'b1;
    mode_req <= 2'h3;
    env_req <= 8'h00;
    stay(8'h0c, 80);
    apb(1'b0, 12'h008, 32'h0, rd, er);
    check("mode", {30'h0, rd[9:8]}, 32'h3);
    env_req <= 8'h40;
    wait_gain(8'h0d, 40);
    summarize();
  end
endmodule
